// file: rtl/scpm_cfg.svh
// Offsets, reset values and timing counts of the slave processor mode and port block.
`ifndef SCPM_CFG_SVH
`define SCPM_CFG_SVH
`define SCPM_P1_DIR 16'h0000
`define SCPM_P2_DIR 16'h0001
`define SCPM_P1_DATA 16'h0002
`define SCPM_P2_DATA 16'h0003
`define SCPM_P3_DIR 16'h0004
`define SCPM_P4_DIR 16'h0005
`define SCPM_P3_DATA 16'h0006
`define SCPM_P4_DATA 16'h0007
`define SCPM_TMR_CS 16'h0008
`define SCPM_CNT_HI 16'h0009
`define SCPM_CNT_LO 16'h000a
`define SCPM_CMP_HI 16'h000b
`define SCPM_CMP_LO 16'h000c
`define SCPM_CPU_STAT 16'h001e
`define SCPM_VEC_HI 16'hfffe
`define SCPM_VEC_LO 16'hffff
`define SCPM_MUX_MODE 3'h6
`define SCPM_MODE_LSB 5
`define SCPM_TMR_OCF 6
`define SCPM_TMR_OLVL 0
`define SCPM_STAT_MASK 0
`define SCPM_STAT_RUN 1
`define SCPM_REG_RST 8'h00
`define SCPM_CNT_RST 16'h0000
`define SCPM_CMP_RST 16'hffff
`define SCPM_VEC_HI_RST 8'hf0
`define SCPM_VEC_LO_RST 8'h00
`define SCPM_CLK_NS 4
`define SCPM_TICK_NS 16
`define SCPM_TICK_CYC (`SCPM_TICK_NS / `SCPM_CLK_NS)
`define SCPM_REG_END 16'h001f
`define SCPM_EXT_END 16'h007f
`define SCPM_IRAM_END 16'h00ff
`define SCPM_VRAM_LO 16'h8000
`define SCPM_VRAM_END 16'h97ff
`define SCPM_IROM_LO 16'hf000
`endif

// file: rtl/scpm_pkg.sv
// Types shared by the slave processor mode and port block.
package scpm_pkg;
    typedef enum logic [2:0] {
        SCPM_ST_LATCH = 3'h0,
        SCPM_ST_VHI = 3'h1,
        SCPM_ST_VLO = 3'h2,
        SCPM_ST_VDONE = 3'h3,
        SCPM_ST_RUN = 3'h4
    } scpm_state_t;
    typedef enum logic [2:0] {
        SCPM_RG_REG = 3'h0,
        SCPM_RG_EXT = 3'h1,
        SCPM_RG_IRAM = 3'h2,
        SCPM_RG_VRAM = 3'h3,
        SCPM_RG_IROM = 3'h4,
        SCPM_RG_NONE = 3'h5
    } scpm_region_t;
    typedef struct packed {
        logic speaker_power;
        logic speaker_output;
        logic serial_pin_out;
        logic serial_pin_in;
        logic tape_head_switch;
        logic tape_write_enable;
        logic tape_erase_head;
        logic tape_motor;
    } scpm_p1_t;
    typedef struct packed {
        logic [2:0] unused_hi;
        logic serial_transmit;
        logic serial_receive;
        logic unused_2;
        logic tape_write_data;
        logic read_data_input;
    } scpm_p2_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } scpm_bus_t;
endpackage

// file: rtl/scpm_sync.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
module scpm_sync (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [31:0] i_async,
    output logic [31:0] o_sync
);
    logic [31:0] s1;
    logic [31:0] s2;
    logic [31:0] s3;
    // The chain runs through reset so that the mode straps are settled when reset is released.
    always_ff @(posedge i_clk) begin
        s1 <= i_async;
        s2 <= s1;
        s3 <= s2;
    end
    genvar g;
    generate
        for (g = 0; g < 32; g = g + 1) begin : g_bit
            always_ff @(posedge i_clk) begin
                if (i_reset || s2[g] == s3[g]) begin
                    o_sync[g] <= s3[g];
                end
            end
        end
    endgenerate
endmodule

// file: rtl/scpm_vec_mem.sv
// Two-byte reset vector store with registered read data.
`timescale 1ns/1ps
`include "scpm_cfg.svh"
module scpm_vec_mem (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_we,
    input wire logic i_waddr,
    input wire logic [7:0] i_wdata,
    input wire logic i_raddr,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:1];
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            mem[0] <= `SCPM_VEC_HI_RST;
            mem[1] <= `SCPM_VEC_LO_RST;
        end else if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule

// file: rtl/scpm_top.sv
// Mode latch, reset sequence, port registers and timer of the slave processor.
//
// Operation
// - Mode comes from port 2 bits 2..0.
// - Mode selection is pure hardware at reset.
// - Latch mode bits first after reset release.
// - Latched mode governs, not live levels.
// - Program counter loaded from vector FFFE/FFFF.
// - Interrupt mask set after reset.
// - Memory map regions up to FFFFH.
// - Direction bits steer ports 1 and 2.
// - Ports 3/4 carry PC low/high address bytes in mode 6, no data.
// - Port 1 bits: speaker, serial, tape lines.
// - Port 2 bits: serial, tape data, read.
// - Sixteen-bit counter and compare value bytes.
`timescale 1ns/1ps
`include "scpm_cfg.svh"
module scpm_top (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire scpm_pkg::scpm_bus_t i_bus,
    output logic [7:0] o_rdata,
    input wire logic [7:0] i_p1_in,
    output scpm_pkg::scpm_p1_t o_p1_out,
    output logic [7:0] o_p1_oe,
    input wire logic [7:0] i_p2_in,
    output scpm_pkg::scpm_p2_t o_p2_out,
    output logic [7:0] o_p2_oe,
    input wire logic [7:0] i_p3_in,
    output logic [7:0] o_p3_out,
    output logic [7:0] o_p3_oe,
    input wire logic [7:0] i_p4_in,
    output logic [7:0] o_p4_out,
    output logic [7:0] o_p4_oe,
    output logic [2:0] o_mode,
    output logic o_mux_mode,
    output logic [15:0] o_pc,
    output scpm_pkg::scpm_region_t o_pc_region,
    output logic o_running,
    output logic o_irq_mask,
    output logic o_cmp_match
);
    // ------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------
    function automatic scpm_pkg::scpm_region_t region_of(input logic [15:0] a);
        if (a <= `SCPM_REG_END) begin
            region_of = scpm_pkg::SCPM_RG_REG;
        end else if (a <= `SCPM_EXT_END) begin
            region_of = scpm_pkg::SCPM_RG_EXT;
        end else if (a <= `SCPM_IRAM_END) begin
            region_of = scpm_pkg::SCPM_RG_IRAM;
        end else if (a >= `SCPM_VRAM_LO && a <= `SCPM_VRAM_END) begin
            region_of = scpm_pkg::SCPM_RG_VRAM;
        end else if (a >= `SCPM_IROM_LO) begin
            region_of = scpm_pkg::SCPM_RG_IROM;
        end else begin
            region_of = scpm_pkg::SCPM_RG_NONE;
        end
    endfunction

    logic [31:0] pins;
    scpm_pkg::scpm_state_t state;
    logic [2:0] mode;
    logic irq_mask;
    logic [7:0] p1_dir;
    logic [7:0] p2_dir;
    logic [7:0] p3_dir;
    logic [7:0] p4_dir;
    scpm_pkg::scpm_p1_t p1_data;
    scpm_pkg::scpm_p2_t p2_data;
    logic [7:0] p3_data;
    logic [7:0] p4_data;
    logic [15:0] cnt;
    logic [15:0] cmp;
    logic ocf;
    logic olvl;
    logic [7:0] div;
    logic tick;
    logic [7:0] vec_rdata;
    logic vec_raddr;
    logic vec_we;
    logic bus_reg;
    logic mux_drive;

    scpm_sync u_sync (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_async({i_p4_in, i_p3_in, i_p2_in, i_p1_in}),
        .o_sync(pins)
    );

    assign vec_we = i_bus.wr && (i_bus.addr[15:1] == 15'(`SCPM_VEC_HI >> 1));
    assign vec_raddr = (state == scpm_pkg::SCPM_ST_VLO);
    assign bus_reg = (region_of(i_bus.addr) == scpm_pkg::SCPM_RG_REG);
    assign mux_drive = (mode == `SCPM_MUX_MODE) && (state == scpm_pkg::SCPM_ST_RUN);

    scpm_vec_mem u_vec (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_we(vec_we),
        .i_waddr(i_bus.addr[0]),
        .i_wdata(i_bus.wdata),
        .i_raddr(vec_raddr),
        .o_rdata(vec_rdata)
    );

    // ------------------------------------------------------------
    // Reset sequence
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state <= scpm_pkg::SCPM_ST_LATCH;
        end else begin
            case (state)
                scpm_pkg::SCPM_ST_LATCH: begin
                    state <= scpm_pkg::SCPM_ST_VHI;
                end
                scpm_pkg::SCPM_ST_VHI: begin
                    state <= scpm_pkg::SCPM_ST_VLO;
                end
                scpm_pkg::SCPM_ST_VLO: begin
                    state <= scpm_pkg::SCPM_ST_VDONE;
                end
                scpm_pkg::SCPM_ST_VDONE: begin
                    state <= scpm_pkg::SCPM_ST_RUN;
                end
                scpm_pkg::SCPM_ST_RUN: begin
                    state <= scpm_pkg::SCPM_ST_RUN;
                end
                default: begin
                    state <= scpm_pkg::SCPM_ST_LATCH;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            mode <= 3'h0;
        end else if (state == scpm_pkg::SCPM_ST_LATCH) begin
            mode <= pins[10:8];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_pc <= 16'h0000;
        end else if (state == scpm_pkg::SCPM_ST_VLO) begin
            o_pc[15:8] <= vec_rdata;
        end else if (state == scpm_pkg::SCPM_ST_VDONE) begin
            o_pc[7:0] <= vec_rdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            irq_mask <= 1'b1;
        end else if (state == scpm_pkg::SCPM_ST_VDONE) begin
            irq_mask <= 1'b1;
        end else if (i_bus.wr && i_bus.addr == `SCPM_CPU_STAT) begin
            irq_mask <= i_bus.wdata[`SCPM_STAT_MASK];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_mode <= 3'h0;
            o_mux_mode <= 1'b0;
            o_running <= 1'b0;
            o_irq_mask <= 1'b1;
            o_pc_region <= scpm_pkg::SCPM_RG_REG;
        end else begin
            o_mode <= mode;
            o_mux_mode <= (mode == `SCPM_MUX_MODE);
            o_running <= (state == scpm_pkg::SCPM_ST_RUN);
            o_irq_mask <= irq_mask;
            o_pc_region <= region_of(o_pc);
        end
    end

    // ------------------------------------------------------------
    // Port registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            p1_dir <= `SCPM_REG_RST;
            p2_dir <= `SCPM_REG_RST;
            p3_dir <= `SCPM_REG_RST;
            p4_dir <= `SCPM_REG_RST;
            p1_data <= `SCPM_REG_RST;
            p2_data <= `SCPM_REG_RST;
            p3_data <= `SCPM_REG_RST;
            p4_data <= `SCPM_REG_RST;
        end else if (i_bus.wr) begin
            case (i_bus.addr)
                `SCPM_P1_DIR: p1_dir <= i_bus.wdata;
                `SCPM_P2_DIR: p2_dir <= i_bus.wdata;
                `SCPM_P3_DIR: p3_dir <= i_bus.wdata;
                `SCPM_P4_DIR: p4_dir <= i_bus.wdata;
                `SCPM_P1_DATA: p1_data <= i_bus.wdata;
                `SCPM_P2_DATA: p2_data <= i_bus.wdata;
                `SCPM_P3_DATA: p3_data <= i_bus.wdata;
                `SCPM_P4_DATA: p4_data <= i_bus.wdata;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_p1_out <= 8'h00;
            o_p1_oe <= 8'h00;
            o_p2_out <= 8'h00;
            o_p2_oe <= 8'h00;
        end else begin
            o_p1_out <= p1_data;
            o_p1_oe <= p1_dir;
            o_p2_out <= p2_data;
            o_p2_oe <= p2_dir;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_p3_out <= 8'h00;
            o_p3_oe <= 8'h00;
            o_p4_out <= 8'h00;
            o_p4_oe <= 8'h00;
        end else if (mux_drive) begin
            o_p3_out <= o_pc[7:0];
            o_p3_oe <= 8'hff;
            o_p4_out <= o_pc[15:8];
            o_p4_oe <= 8'hff;
        end else begin
            o_p3_out <= p3_data;
            o_p3_oe <= p3_dir;
            o_p4_out <= p4_data;
            o_p4_oe <= p4_dir;
        end
    end

    // ------------------------------------------------------------
    // Timer
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            div <= 8'h00;
            tick <= 1'b0;
        end else if (div == 8'(`SCPM_TICK_CYC - 1)) begin
            div <= 8'h00;
            tick <= 1'b1;
        end else begin
            div <= div + 8'h01;
            tick <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cnt <= `SCPM_CNT_RST;
        end else if (i_bus.wr && i_bus.addr == `SCPM_CNT_HI) begin
            cnt[15:8] <= i_bus.wdata;
        end else if (i_bus.wr && i_bus.addr == `SCPM_CNT_LO) begin
            cnt[7:0] <= i_bus.wdata;
        end else if (tick) begin
            cnt <= cnt + 16'h0001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cmp <= `SCPM_CMP_RST;
        end else if (i_bus.wr && i_bus.addr == `SCPM_CMP_HI) begin
            cmp[15:8] <= i_bus.wdata;
        end else if (i_bus.wr && i_bus.addr == `SCPM_CMP_LO) begin
            cmp[7:0] <= i_bus.wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ocf <= 1'b0;
            olvl <= 1'b0;
            o_cmp_match <= 1'b0;
        end else begin
            o_cmp_match <= tick && (cnt == cmp);
            if (tick && cnt == cmp) begin
                ocf <= 1'b1;
            end else if (i_bus.wr && i_bus.addr == `SCPM_TMR_CS) begin
                ocf <= 1'b0;
            end
            if (i_bus.wr && i_bus.addr == `SCPM_TMR_CS) begin
                olvl <= i_bus.wdata[`SCPM_TMR_OLVL];
            end
        end
    end

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else if (i_bus.rd && bus_reg) begin
            case (i_bus.addr)
                `SCPM_P1_DIR: o_rdata <= p1_dir;
                `SCPM_P2_DIR: o_rdata <= p2_dir;
                `SCPM_P3_DIR: o_rdata <= p3_dir;
                `SCPM_P4_DIR: o_rdata <= p4_dir;
                `SCPM_P1_DATA: o_rdata <= (p1_dir & p1_data) | (~p1_dir & pins[7:0]);
                `SCPM_P2_DATA: o_rdata <= {mode, (p2_dir[4:0] & p2_data[4:0]) | (~p2_dir[4:0] & pins[12:8])};
                `SCPM_P3_DATA: o_rdata <= (p3_dir & p3_data) | (~p3_dir & pins[23:16]);
                `SCPM_P4_DATA: o_rdata <= (p4_dir & p4_data) | (~p4_dir & pins[31:24]);
                `SCPM_TMR_CS: o_rdata <= {1'b0, ocf, 5'h00, olvl};
                `SCPM_CNT_HI: o_rdata <= cnt[15:8];
                `SCPM_CNT_LO: o_rdata <= cnt[7:0];
                `SCPM_CMP_HI: o_rdata <= cmp[15:8];
                `SCPM_CMP_LO: o_rdata <= cmp[7:0];
                `SCPM_CPU_STAT: o_rdata <= {6'h00, (state == scpm_pkg::SCPM_ST_RUN), irq_mask};
                default: o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_vector;
        state == scpm_pkg::SCPM_ST_VHI ##1 state == scpm_pkg::SCPM_ST_VLO ##1 state == scpm_pkg::SCPM_ST_VDONE;
    endsequence
    sequence s_boot;
        state == scpm_pkg::SCPM_ST_LATCH ##1 s_vector ##1 state == scpm_pkg::SCPM_ST_RUN;
    endsequence

    property p_boot;
        $fell(i_reset) |-> s_boot;
    endproperty
    a_boot: assert property (p_boot) else $error("reset sequence order wrong");

    property p_latch;
        !i_reset && state == scpm_pkg::SCPM_ST_LATCH |=> mode == $past(pins[10:8]);
    endproperty
    a_latch: assert property (p_latch) else $error("mode not latched at release");

    property p_hold;
        state != scpm_pkg::SCPM_ST_LATCH |=> $stable(mode);
    endproperty
    a_hold: assert property (p_hold) else $error("mode changed after latch");

    property p_pc_hi;
        state == scpm_pkg::SCPM_ST_VLO |=> o_pc[15:8] == $past(vec_rdata);
    endproperty
    a_pc_hi: assert property (p_pc_hi) else $error("pc high byte not from vector");

    property p_pc_lo;
        state == scpm_pkg::SCPM_ST_VDONE |=> o_pc[7:0] == $past(vec_rdata) ##1 o_running;
    endproperty
    a_pc_lo: assert property (p_pc_lo) else $error("pc low byte not from vector");

    property p_mask;
        state == scpm_pkg::SCPM_ST_VDONE |=> irq_mask ##1 o_irq_mask;
    endproperty
    a_mask: assert property (p_mask) else $error("interrupt mask not set");

    property p_dir;
        1'b1 |=> o_p1_oe == $past(p1_dir) && o_p2_oe == $past(p2_dir);
    endproperty
    a_dir: assert property (p_dir) else $error("direction not applied");

    property p_mux;
        mux_drive |=> o_p4_out == $past(o_pc[15:8]) && o_p3_oe == 8'hff;
    endproperty
    a_mux: assert property (p_mux) else $error("multiplexed bus not driven");

    property p_count;
        tick && !i_bus.wr |=> cnt == $past(cnt) + 16'h0001;
    endproperty
    a_count: assert property (p_count) else $error("counter did not advance");

    property p_cmp;
        tick && cnt == cmp |=> ocf && o_cmp_match;
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare match missed");
endmodule

// file: test/scpm_far_side.sv
// Far-side model of the tape drive, speaker and serial lines and the mode straps.
`timescale 1ns/1ps
module scpm_far_side (
    input wire scpm_pkg::scpm_p1_t i_p1_out,
    input wire logic [7:0] i_p1_oe,
    input wire scpm_pkg::scpm_p2_t i_p2_out,
    input wire logic [7:0] i_p2_oe,
    input wire logic [2:0] i_strap,
    input wire logic [7:0] i_ext,
    output logic [7:0] o_p1_pin,
    output logic [7:0] o_p2_pin
);
    logic [7:0] p1_lvl;
    logic [7:0] p2_far;
    // Each port 1 wire carries the device level where driven, else the far side level.
    assign p1_lvl = (i_p1_oe & i_p1_out) | (~i_p1_oe & i_ext);
    // A loopback plug ties the serial pin input to the serial pin output.
    assign o_p1_pin = {p1_lvl[7:5], p1_lvl[5], p1_lvl[3:0]};
    // Straps sit on port 2 bits 2..0; the board normally selects mode 6.
    assign p2_far = {i_ext[7:3], i_strap};
    assign o_p2_pin = (i_p2_oe & i_p2_out) | (~i_p2_oe & p2_far);
endmodule

// file: test/slave_cpu_mode_and_port_map_bench.sv
// Self-checking bench of the slave processor mode and port block.
`timescale 1ns/1ps
module slave_cpu_mode_and_port_map_bench;
    logic clk;
    logic reset;
    scpm_pkg::scpm_bus_t bus;
    logic [7:0] rdata;
    logic [7:0] p1_pin;
    logic [7:0] p2_pin;
    scpm_pkg::scpm_p1_t p1_out;
    scpm_pkg::scpm_p2_t p2_out;
    logic [7:0] p1_oe;
    logic [7:0] p2_oe;
    logic [7:0] p3_out;
    logic [7:0] p3_oe;
    logic [7:0] p4_out;
    logic [7:0] p4_oe;
    logic [2:0] mode;
    logic mux_mode;
    logic [15:0] pc;
    scpm_pkg::scpm_region_t pc_region;
    logic running;
    logic irq_mask;
    logic cmp_match;
    logic [2:0] strap;
    logic [7:0] ext;
    logic [7:0] m [0:12];
    logic [2:0] mode_l;
    logic tflag;
    logic mask;
    int error_cnt;
    int n_compared;
    int seed;
    int k;
    int a;

    scpm_top dut (.i_clk(clk), .i_reset(reset), .i_bus(bus), .o_rdata(rdata),
        .i_p1_in(p1_pin), .o_p1_out(p1_out), .o_p1_oe(p1_oe),
        .i_p2_in(p2_pin), .o_p2_out(p2_out), .o_p2_oe(p2_oe),
        .i_p3_in(ext), .o_p3_out(p3_out), .o_p3_oe(p3_oe),
        .i_p4_in(~ext), .o_p4_out(p4_out), .o_p4_oe(p4_oe),
        .o_mode(mode), .o_mux_mode(mux_mode), .o_pc(pc), .o_pc_region(pc_region),
        .o_running(running), .o_irq_mask(irq_mask), .o_cmp_match(cmp_match));

    scpm_far_side far (.i_p1_out(p1_out), .i_p1_oe(p1_oe), .i_p2_out(p2_out), .i_p2_oe(p2_oe),
        .i_strap(strap), .i_ext(ext), .o_p1_pin(p1_pin), .o_p2_pin(p2_pin));

    // ----------------------------------------
    // Clock, verdict and watchdog.
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic report_and_stop();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end

    // ----------------------------------------
    // Model, comparison and bus tasks.
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] e, input string what);
        n_compared++;
        if (got !== e) begin
            error_cnt++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, e);
        end
    endtask

    function automatic logic [7:0] exp_rd(input int r);
        logic [7:0] l;
        logic [7:0] q;
        case (r)
            2: begin
                l = (m[0] & m[2]) | (~m[0] & ext);
                q = {l[7:5], l[5], l[3:0]};
                return (m[0] & m[2]) | (~m[0] & q);
            end
            3: begin
                q = (m[1] & m[3]) | (~m[1] & {ext[7:3], strap});
                return {mode_l, q[4:0]};
            end
            6: return (m[4] & m[6]) | (~m[4] & ext);
            7: return (m[5] & m[7]) | (~m[5] & ~ext);
            8: return {1'b0, tflag, 5'h00, m[8][0]};
            30: return {6'h00, 1'b1, mask};
            0, 1, 4, 5, 11, 12: return m[r];
            default: return 8'h00;
        endcase
    endfunction

    task automatic wr(input logic [15:0] ad, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '{addr: ad, wdata: d, wr: 1'b0, rd: 1'b0};
        if (ad < 16'h000d && ad != 16'h0009 && ad != 16'h000a) m[ad[3:0]] = d;
        if (ad == 16'h0008) begin
            m[8] = {7'h00, d[0]};
            tflag = 1'b0;
        end
        if (ad == 16'h001e) mask = d[0];
    endtask

    task automatic rd_chk(input logic [15:0] ad);
        logic [7:0] e;
        e = exp_rd(int'(ad));
        @(posedge clk);
        bus <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
        #1;
        chk(rdata, e, "read");
    endtask

    task automatic boot(input logic [2:0] s);
        int w;
        @(posedge clk);
        reset <= 1'b1;
        strap <= s;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        for (w = 0; w < 20 && running !== 1'b1; w++) @(posedge clk);
        repeat (2) @(posedge clk);
        #1;
        foreach (m[i]) m[i] = (i > 10) ? 8'hff : 8'h00;
        tflag = 1'b0;
        mask = 1'b1;
        mode_l = s;
        chk(running, 1'b1, "running");
        chk(mode, s, "mode");
        chk(mux_mode, s == 3'h6, "mux");
        chk(pc, 16'hf000, "pc");
        chk(irq_mask, 1'b1, "mask");
        chk(pc_region, scpm_pkg::SCPM_RG_IROM, "region");
        chk({p4_oe, p3_oe}, (s == 3'h6) ? 16'hffff : 16'h0000, "p34 oe");
        chk({p4_out, p3_out}, (s == 3'h6) ? pc : 16'h0000, "p34 out");
    endtask

    // ----------------------------------------
    // Main sequence.
    // ----------------------------------------
    initial begin
        seed = 74;
        error_cnt = 0;
        n_compared = 0;
        reset = 1'b1;
        bus = '{addr: 16'h0000, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
        strap = 3'h6;
        ext = 8'h5a;
        boot(3'h6);
        strap <= 3'h1;
        repeat (10) @(posedge clk);
        chk(mode, 3'h6, "live strap");
        rd_chk(16'h0003);
        for (a = 0; a < 13; a++) begin
            if (a != 9 && a != 10) rd_chk(a[15:0]);
        end
        rd_chk(16'h000d);
        wr(16'h000d, 8'hff);
        rd_chk(16'h000d);
        wr(16'h001e, 8'h00);
        @(posedge clk) #1;
        chk(irq_mask, 1'b0, "mask clear");
        rd_chk(16'h001e);
        // Timer: reload the counter, then expect one compare pulse at 0040.
        wr(16'h0009, 8'h00);
        wr(16'h000a, 8'h00);
        wr(16'h000b, 8'h00);
        wr(16'h000c, 8'h40);
        for (k = 0; k < 400 && cmp_match !== 1'b1; k++) @(posedge clk) #1;
        chk(k >= 232 && k <= 264, 1'b1, "match time");
        @(posedge clk) #1;
        chk(cmp_match, 1'b0, "match pulse");
        tflag = 1'b1;
        rd_chk(16'h0008);
        wr(16'h0008, 8'h01);
        rd_chk(16'h0008);
        rd_chk(16'h0009);
        // Every mode code, walked downwards so the last boot is non-multiplexed.
        for (a = 7; a >= 0; a--) boot(a[2:0]);
        // Random port traffic with the far side changing its levels.
        repeat (6) begin
            for (a = 0; a < 8; a++) wr(a[15:0], 8'($random(seed)));
            wr(16'h000b, 8'($random(seed)));
            @(posedge clk);
            ext <= 8'($random(seed));
            repeat (8) @(posedge clk);
            #1;
            chk({p1_oe, p1_out}, {m[0], m[2]}, "p1 pins");
            chk({p2_oe, p2_out}, {m[1], m[3]}, "p2 pins");
            chk({p3_oe, p3_out}, {m[4], m[6]}, "p3 pins");
            chk({p4_oe, p4_out}, {m[5], m[7]}, "p4 pins");
            for (a = 0; a < 8; a++) rd_chk(a[15:0]);
            rd_chk(16'h000b);
        end
        report_and_stop();
    end
endmodule
